// File: reload_timer_pkg.sv
// constants shared by the reload timer design files
package reload_timer_pkg;
	// apb byte addresses
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] MODE_ADDR = 8'h04;
	localparam logic [7:0] CNTL_ADDR = 8'h08;
	localparam logic [7:0] CNTH_ADDR = 8'h0C;
	localparam logic [7:0] RELL_ADDR = 8'h10;
	localparam logic [7:0] RELH_ADDR = 8'h14;
	// timer_control_reg fields
	localparam int OVF_BIT = 7;
	localparam int EXT_BIT = 6;
	localparam int RXSEL_BIT = 5;
	localparam int TXSEL_BIT = 4;
	localparam int EXTEN_BIT = 3;
	localparam int RUN_BIT = 2;
	localparam int SRC_BIT = 1;
	localparam int CRSEL_BIT = 0;
	// timer_mode_reg fields
	localparam int REQEN_BIT = 7;
	localparam int CLKOE_BIT = 1;
	localparam int DOWN_COUNT_ENABLE_BIT = 0;
	// reset values and counter maximum
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [15:0] REL_RST = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	// timing: machine cycle length and serial bit divider
	localparam logic [2:0] MC_LAST = 3'h5;
	localparam logic [3:0] BIT_DIV_LAST = 4'hF;
endpackage

// File: pin_sync.sv
// two-flop pin synchroniser with falling edge pulse
`timescale 1ns/100ps
`default_nettype none
module pin_sync
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// raw pin
	input wire logic pin_i,
	// synchronised level and falling edge
	output logic level_o,
	output logic fall_o
);
	logic meta_r;
	logic sync_r;
	logic prev_r;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_r <= 1'b1;
			sync_r <= 1'b1;
			prev_r <= 1'b1;
		end
		else
		begin
			meta_r <= pin_i;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign level_o = sync_r;
	assign fall_o = prev_r & ~sync_r;
endmodule
`default_nettype wire

// File: reload_timer.sv
// 16-bit reload timer with baud generation and clock-out, apb slave
// How it works
// - no trigger: count up, overflow, reload
// - source select chooses pin events or machine cycles
// - trigger falling edge reloads and sets flag
// - either flag raises the enabled timer request
// - edge seen high, low, flag third cycle
// - up/down, trigger high: count up, reload
// - trigger low: count down, underflow to ones
// - up/down toggles external flag each wrap
// - clock-out drives square wave on pin
// - clock-out frequency osc over twice span
// - clock-out rollovers give no request
// - select bits route overflows to serial clocks
// - baud mode reloads on every rollover
// - serial bit rate is overflow rate/16
// - baud timing counts at oscillator rate unless pin source set
// - baud rollover sets no overflow flag
// - baud trigger edge sets flag, no reload
// - baud mode only while a select set
// - down count enable clear after reset
// - baud selects force auto-reload over capture
// - timer runs only while run control set
`timescale 1ns/100ps
`default_nettype none
module reload_timer
	import reload_timer_pkg::*;
(
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins
	input wire logic trigger_input,
	input wire logic counter_pin_i,
	output logic counter_pin_o,
	output logic counter_pin_oe_n,
	// serial port clocking
	input wire logic other_timer_ovf,
	output logic tx_bit_tick,
	output logic rx_bit_tick,
	// timer interrupt request
	output logic timer_req
);

	////////////////////////////////////////////////////////////////
	// registers and decode

	logic overflow_flag_r;
	logic external_flag_r;
	logic [5:0] ctrl_r;
	logic [7:0] mode_r;
	logic [15:0] count_r;
	logic [15:0] count_nxt;
	logic [15:0] reload_r;
	logic [2:0] mc_r;
	logic samp_r;
	logic pend_r;
	logic clk_out_r;
	logic [3:0] tx_div_r;
	logic [3:0] rx_div_r;
	logic [31:0] rdata_nxt;
	logic trig_s;
	logic pin_fall;
	logic wr;
	logic ctrl_wr;
	logic cnt_wr;
	logic mapped;
	logic mc_tick;
	logic baud;
	logic clkout;
	logic updown;
	logic tick;
	logic count_down;
	logic ovf_ev;
	logic unf_ev;
	logic ext_ev;
	logic ext_reload;
	logic my_ovf;

	function automatic logic [3:0] div_next(input logic [3:0] d, input logic ev);
		div_next = ev ? d + 4'h1 : d;
	endfunction

	function automatic logic is_addr(input logic [7:0] a, input logic [7:0] r);
		is_addr = (a == r);
	endfunction

	assign wr = psel & penable & pwrite;
	assign ctrl_wr = wr & is_addr(paddr, CTRL_ADDR);
	assign cnt_wr = wr & (is_addr(paddr, CNTL_ADDR) | is_addr(paddr, CNTH_ADDR));
	assign mapped = is_addr(paddr, CTRL_ADDR) | is_addr(paddr, MODE_ADDR) | is_addr(paddr, CNTL_ADDR)
		| is_addr(paddr, CNTH_ADDR) | is_addr(paddr, RELL_ADDR) | is_addr(paddr, RELH_ADDR);
	// zero wait states; errors only for unmapped words
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	////////////////////////////////////////////////////////////////
	// pin synchronisers

	pin_sync trig_sync
	(
		.pclk(pclk),
		.presetn(presetn),
		.pin_i(trigger_input),
		.level_o(trig_s),
		.fall_o()
	);

	pin_sync cpin_sync
	(
		.pclk(pclk),
		.presetn(presetn),
		.pin_i(counter_pin_i),
		.level_o(),
		.fall_o(pin_fall)
	);

	////////////////////////////////////////////////////////////////
	// mode decode and count enable

	assign baud = ctrl_r[RXSEL_BIT] | ctrl_r[TXSEL_BIT];
	assign clkout = mode_r[CLKOE_BIT] & ~ctrl_r[SRC_BIT];
	assign updown = mode_r[DOWN_COUNT_ENABLE_BIT] & ~baud & ~clkout;
	assign count_down = updown & ~trig_s;
	assign mc_tick = (mc_r == MC_LAST);

	// pin source counts pin falls; else baud and clock-out time at the oscillator, else once per machine cycle
	always_comb
	begin
		if (!ctrl_r[RUN_BIT])
			tick = 1'b0;
		else if (ctrl_r[SRC_BIT])
			tick = pin_fall;
		else if (baud | clkout)
			tick = 1'b1;
		else
			tick = mc_tick;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mc_r <= 3'h0;
		else if (mc_tick)
			mc_r <= 3'h0;
		else
			mc_r <= mc_r + 3'h1;
	end

	////////////////////////////////////////////////////////////////
	// trigger edge: high in one machine cycle, low in next, event in third

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			samp_r <= 1'b1;
			pend_r <= 1'b0;
		end
		else if (mc_tick)
		begin
			samp_r <= trig_s;
			pend_r <= samp_r & ~trig_s;
		end
	end

	assign ext_ev = mc_tick & pend_r & ctrl_r[EXTEN_BIT];
	// capture select is ignored in baud mode; up/down uses the pin as direction
	assign ext_reload = ext_ev & ~baud & ~updown & (~ctrl_r[CRSEL_BIT] | baud);

	////////////////////////////////////////////////////////////////
	// counter

	assign ovf_ev = tick & ~count_down & (count_r == CNT_MAX) & ~ext_reload;
	assign unf_ev = tick & count_down & (count_r == reload_r) & ~ext_reload;
	assign my_ovf = ovf_ev;

	always_comb
	begin
		count_nxt = count_r;
		if (ext_reload)
			count_nxt = reload_r;
		else if (unf_ev)
			count_nxt = CNT_MAX;
		else if (ovf_ev)
			count_nxt = reload_r;
		else if (tick & count_down)
			count_nxt = count_r - 16'h0001;
		else if (tick)
			count_nxt = count_r + 16'h0001;
	end

	// a software write wins over counting in the written byte only; the other byte still counts; stopping first avoids the race
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count_r <= CNT_RST;
		else if (wr & is_addr(paddr, CNTL_ADDR))
			count_r <= {count_nxt[15:8], pwdata[7:0]};
		else if (wr & is_addr(paddr, CNTH_ADDR))
			count_r <= {pwdata[7:0], count_nxt[7:0]};
		else
			count_r <= count_nxt;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			reload_r <= REL_RST;
		else if (wr & is_addr(paddr, RELL_ADDR))
			reload_r[7:0] <= pwdata[7:0];
		else if (wr & is_addr(paddr, RELH_ADDR))
			reload_r[15:8] <= pwdata[7:0];
	end

	////////////////////////////////////////////////////////////////
	// control, mode and flags

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_r <= CTRL_RST[5:0];
			mode_r <= MODE_RST;
		end
		else
		begin
			if (ctrl_wr)
				ctrl_r <= pwdata[5:0];
			if (wr & is_addr(paddr, MODE_ADDR))
				mode_r <= {pwdata[REQEN_BIT], 5'h00, pwdata[CLKOE_BIT], pwdata[DOWN_COUNT_ENABLE_BIT]};
		end
	end

	// hardware set wins over a software clear in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			overflow_flag_r <= 1'b0;
		else if ((ovf_ev | unf_ev) & ~baud & ~clkout)
			overflow_flag_r <= 1'b1;
		else if (ctrl_wr)
			overflow_flag_r <= pwdata[OVF_BIT];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			external_flag_r <= 1'b0;
		else if (updown & (ovf_ev | unf_ev))
			external_flag_r <= ~external_flag_r;
		else if (ext_ev & ~updown)
			external_flag_r <= 1'b1;
		else if (ctrl_wr)
			external_flag_r <= pwdata[EXT_BIT];
	end

	assign timer_req = mode_r[REQEN_BIT] & (overflow_flag_r | external_flag_r);

	////////////////////////////////////////////////////////////////
	// clock-out pin

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			clk_out_r <= 1'b0;
		else if (!clkout)
			clk_out_r <= 1'b0;
		else if (ovf_ev)
			clk_out_r <= ~clk_out_r;
	end

	assign counter_pin_o = clk_out_r;
	assign counter_pin_oe_n = ~clkout;

	////////////////////////////////////////////////////////////////
	// serial clock routing and divide by sixteen

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_div_r <= 4'h0;
			rx_div_r <= 4'h0;
		end
		else
		begin
			tx_div_r <= div_next(tx_div_r, ctrl_r[TXSEL_BIT] ? my_ovf : other_timer_ovf);
			rx_div_r <= div_next(rx_div_r, ctrl_r[RXSEL_BIT] ? my_ovf : other_timer_ovf);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_bit_tick <= 1'b0;
			rx_bit_tick <= 1'b0;
		end
		else
		begin
			tx_bit_tick <= (tx_div_r == BIT_DIV_LAST) & (ctrl_r[TXSEL_BIT] ? my_ovf : other_timer_ovf);
			rx_bit_tick <= (rx_div_r == BIT_DIV_LAST) & (ctrl_r[RXSEL_BIT] ? my_ovf : other_timer_ovf);
		end
	end

	////////////////////////////////////////////////////////////////
	// read data, captured in the setup cycle

	always_comb
	begin
		rdata_nxt = 32'h0000_0000;
		if (is_addr(paddr, CTRL_ADDR))
			rdata_nxt[7:0] = {overflow_flag_r, external_flag_r, ctrl_r};
		else if (is_addr(paddr, MODE_ADDR))
			rdata_nxt[7:0] = mode_r;
		else if (is_addr(paddr, CNTL_ADDR))
			rdata_nxt[7:0] = count_r[7:0];
		else if (is_addr(paddr, CNTH_ADDR))
			rdata_nxt[7:0] = count_r[15:8];
		else if (is_addr(paddr, RELL_ADDR))
			rdata_nxt[7:0] = reload_r[7:0];
		else if (is_addr(paddr, RELH_ADDR))
			rdata_nxt[7:0] = reload_r[15:8];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel & ~penable)
			prdata <= rdata_nxt;
	end

	////////////////////////////////////////////////////////////////
	// checks

	sequence up_wrap_s;
		tick && !count_down && count_r == CNT_MAX && !ext_reload && !cnt_wr;
	endsequence

	sequence reloaded_s;
		count_r == $past(reload_r);
	endsequence

	up_reload_a: assert property (@(posedge pclk) disable iff (!presetn) up_wrap_s |=> reloaded_s)
		else $error("counter not reloaded on overflow");

	sequence down_wrap_s;
		unf_ev && !cnt_wr;
	endsequence

	down_reload_a: assert property (@(posedge pclk) disable iff (!presetn) down_wrap_s |=> count_r == 16'hFFFF)
		else $error("counter not all ones after underflow");

	ovf_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		ovf_ev && !baud && !clkout |=> overflow_flag_r)
		else $error("overflow flag not set");

	baud_noflag_a: assert property (@(posedge pclk) disable iff (!presetn)
		(baud || clkout) && !overflow_flag_r && !ctrl_wr |=> !overflow_flag_r)
		else $error("overflow flag set in baud or clock-out mode");

	ext_toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
		updown && (ovf_ev || unf_ev) |=> external_flag_r != $past(external_flag_r))
		else $error("external flag did not toggle");

	edge_three_a: assert property (@(posedge pclk) disable iff (!presetn)
		mc_tick && samp_r && !trig_s && ctrl_r[EXTEN_BIT] && !updown && !ctrl_wr ##1 !ctrl_wr [*6] |=> external_flag_r)
		else $error("trigger edge did not set external flag");

	run_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl_r[RUN_BIT] && !cnt_wr && !ext_reload |=> $stable(count_r))
		else $error("counter moved while stopped");

	baud_noreload_a: assert property (@(posedge pclk) disable iff (!presetn)
		baud && ext_ev && !ovf_ev && !cnt_wr |=> count_r == $past(count_r) + {15'h0000, $past(tick)})
		else $error("trigger edge reloaded in baud mode");

	clk_toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
		clkout && ovf_ev ##1 clkout |-> counter_pin_o != $past(counter_pin_o))
		else $error("clock-out pin did not toggle");

	down_count_enable_reset_a: assert property (@(posedge pclk) $rose(presetn) |-> !mode_r[DOWN_COUNT_ENABLE_BIT])
		else $error("down count enable set after reset");

endmodule
`default_nettype wire

// File: far_side_model.sv
// far side model: trigger pin, counter pin source, other timer overflow
`timescale 1ns/100ps
`default_nettype none
module far_side_model
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// bench commands
	input wire logic trig_lvl,
	input wire logic ext_clk_en,
	// pins toward the timer
	output logic trigger_input,
	output logic pin_drv,
	output logic other_timer_ovf,
	// falling edges made so far
	output logic [15:0] falls
);
	logic [2:0] pin_div_r;
	logic [2:0] ovf_div_r;
	////////////////
	// external clock at fosc/12; always parks high so no stray edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_div_r <= 3'h0;
			pin_drv <= 1'b1;
			falls <= 16'h0000;
		end
		else if (ext_clk_en || !pin_drv)
		begin
			pin_div_r <= (pin_div_r == 3'h5) ? 3'h0 : pin_div_r + 3'h1;
			if (pin_div_r == 3'h5)
			begin
				pin_drv <= !pin_drv;
				falls <= falls + {15'h0000, pin_drv};
			end
		end
	end
	// other timer overflows once in 8 clocks
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ovf_div_r <= 3'h0;
			other_timer_ovf <= 1'b0;
		end
		else
		begin
			ovf_div_r <= ovf_div_r + 3'h1;
			other_timer_ovf <= (ovf_div_r == 3'h7);
		end
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			trigger_input <= 1'b1;
		else
			trigger_input <= trig_lvl;
	end
endmodule
`default_nettype wire

// File: reload_timer_baud_clockout_tb_top.sv
// self-checking testbench for the reload timer
`timescale 1ns/100ps
`default_nettype none
module reload_timer_baud_clockout_tb_top;
	import reload_timer_pkg::*;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] q; logic e;} row_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic trig_lvl, ext_clk_en, pin_drv, pin_o, pin_q, oe_n, ovf_o, tx_t, rx_t, req, trig_pin;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] falls, f0;
	int n_errors, cmp_count, n;
	wire logic pin_lvl = oe_n ? pin_drv : pin_o;
	wire logic pin_chg = pin_o ^ pin_q;
	row_t rows [9] = '{'{MODE_ADDR, 8'hFF, 8'h83, 1'b0}, '{MODE_ADDR, 8'h00, 8'h00, 1'b0},
		'{CNTL_ADDR, 8'hA5, 8'hA5, 1'b0}, '{CNTH_ADDR, 8'h5A, 8'h5A, 1'b0}, '{RELL_ADDR, 8'h3C, 8'h3C, 1'b0},
		'{RELH_ADDR, 8'hC3, 8'hC3, 1'b0}, '{8'h18, 8'hFF, 8'h00, 1'b1}, '{CTRL_ADDR, 8'h03, 8'h03, 1'b0},
		'{CTRL_ADDR, 8'h00, 8'h00, 1'b0}};
	reload_timer i_reload_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .trigger_input(trig_pin), .counter_pin_i(pin_lvl), .counter_pin_o(pin_o),
		.counter_pin_oe_n(oe_n), .other_timer_ovf(ovf_o), .tx_bit_tick(tx_t), .rx_bit_tick(rx_t),
		.timer_req(req));
	far_side_model i_far_side_model (.pclk(pclk), .presetn(presetn), .trig_lvl(trig_lvl),
		.ext_clk_en(ext_clk_en), .trigger_input(trig_pin), .pin_drv(pin_drv), .other_timer_ovf(ovf_o),
		.falls(falls));
	////////////////
	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	always @(posedge pclk) pin_q <= pin_o;
	task give_verdict;
		if (n_errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one apb transfer; request held until pready is sampled high
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait for the slave
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0000_00, d});
	endtask
	task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, rd, exp);
	endtask
	task setv(input logic [7:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(a + 8'h04, v[15:8]);
	endtask
	task wait_cyc(input int c);
		repeat (c) @(posedge pclk);
	endtask
	function logic pick(input int w);
		return w == 0 ? tx_t : (w == 1 ? rx_t : pin_chg);
	endfunction
	// cycles between two consecutive highs of the picked signal
	task gap(input int w, output int g);
		int k;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pick(w) !== 1'b1 && k < 400);
		g = 0;
		do
		begin
			@(posedge pclk);
			g++;
		end
		while (pick(w) !== 1'b1 && g < 400);
	endtask
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		trig_lvl = 1'b1;
		ext_clk_en = 1'b0;
		n_errors = 0;
		cmp_count = 0;
		presetn = 1'b0;
		wait_cyc(5);
		presetn <= 1'b1;
		chk("oe_n", 32'(oe_n), 32'h0000_0001);
		for (int i = 0; i < 6; i++)
			rdc("reset", 8'(4 * i), 32'h0000_0000);
		foreach (rows[j])
		begin
			wr(rows[j].a, rows[j].d);
			chk("wr_err", 32'(err), 32'(rows[j].e));
			rdc("row", rows[j].a, 32'(rows[j].q));
			chk("rd_err", 32'(err), 32'(rows[j].e));
		end
		setv(RELL_ADDR, 16'hFFF0);
		setv(CNTL_ADDR, 16'hFFFE);
		wr(MODE_ADDR, 8'h80);
		wr(CTRL_ADDR, 8'h04);
		wait_cyc(30);
		chk("req", 32'(req), 32'h0000_0001);
		rdc("ctrl", CTRL_ADDR, 32'h0000_0084);
		rdc("cnth", CNTH_ADDR, 32'h0000_00FF);
		wr(CTRL_ADDR, 8'h00);
		@(posedge pclk);
		chk("req", 32'(req), 32'h0000_0000);
		apb(1'b0, CNTL_ADDR, 32'h0000_0000);
		f0 = rd[15:0];
		wait_cyc(20);
		rdc("stopped", CNTL_ADDR, {16'h0000, f0});
		// trigger edge while counting far from overflow
		setv(CNTL_ADDR, 16'h1234);
		wr(CTRL_ADDR, 8'h0C);
		trig_lvl <= 1'b0;
		wait_cyc(40);
		rdc("ctrl", CTRL_ADDR, 32'h0000_004C);
		rdc("cnth", CNTH_ADDR, 32'h0000_00FF);
		wr(CTRL_ADDR, 8'h00);
		wr(MODE_ADDR, 8'h01);
		setv(RELL_ADDR, 16'h0010);
		setv(CNTL_ADDR, 16'h0012);
		wr(CTRL_ADDR, 8'h04);
		wait_cyc(40);
		rdc("ctrl", CTRL_ADDR, 32'h0000_00C4);
		wr(CTRL_ADDR, 8'h00);
		rdc("cnth", CNTH_ADDR, 32'h0000_00FF);
		trig_lvl <= 1'b1;
		setv(CNTL_ADDR, 16'hFFFE);
		wr(CTRL_ADDR, 8'h04);
		wait_cyc(40);
		rdc("ctrl", CTRL_ADDR, 32'h0000_00C4);
		wr(CTRL_ADDR, 8'h00);
		rdc("cnth", CNTH_ADDR, 32'h0000_0000);
		// clock-out with the request enabled, which must stay quiet
		wr(MODE_ADDR, 8'h82);
		setv(RELL_ADDR, 16'hFFFC);
		setv(CNTL_ADDR, 16'hFFFC);
		wr(CTRL_ADDR, 8'h04);
		gap(2, n);
		chk("oe_n", 32'(oe_n), 32'h0000_0000);
		chk("half", 32'(n), 32'h0000_0004);
		rdc("ctrl", CTRL_ADDR, 32'h0000_0004);
		chk("req", 32'(req), 32'h0000_0000);
		wr(CTRL_ADDR, 8'h00);
		wr(MODE_ADDR, 8'h80);
		setv(CNTL_ADDR, 16'hFFFC);
		wr(CTRL_ADDR, 8'h15);
		gap(0, n);
		chk("tx_gap", 32'(n), 32'h0000_0040);
		gap(1, n);
		chk("rx_gap", 32'(n), 32'h0000_0080);
		rdc("ctrl", CTRL_ADDR, 32'h0000_0015);
		chk("req", 32'(req), 32'h0000_0000);
		wr(CTRL_ADDR, 8'h1C);
		trig_lvl <= 1'b0;
		wait_cyc(40);
		rdc("ctrl", CTRL_ADDR, 32'h0000_005C);
		gap(0, n);
		chk("tx_gap", 32'(n), 32'h0000_0040);
		wr(CTRL_ADDR, 8'h04);
		wait_cyc(40);
		rdc("ctrl", CTRL_ADDR, 32'h0000_0084);
		wr(CTRL_ADDR, 8'h00);
		// counting events from the counter pin
		setv(CNTL_ADDR, 16'h0000);
		wr(MODE_ADDR, 8'h00);
		wr(CTRL_ADDR, 8'h06);
		f0 = falls;
		ext_clk_en <= 1'b1;
		wait_cyc(150);
		ext_clk_en <= 1'b0;
		wait_cyc(30);
		wr(CTRL_ADDR, 8'h00);
		rdc("events", CNTL_ADDR, {24'h0000_00, 8'(falls - f0)});
		// reset in mid-run with clock-out driving and down count enabled
		wr(MODE_ADDR, 8'h83);
		wr(CTRL_ADDR, 8'h04);
		wait_cyc(3);
		chk("run_oe_n", 32'(oe_n), 32'h0000_0000);
		presetn <= 1'b0;
		wait_cyc(2);
		chk("rst_oe_n", 32'(oe_n), 32'h0000_0001);
		chk("rst_pin", 32'(pin_o), 32'h0000_0000);
		chk("rst_req", 32'(req), 32'h0000_0000);
		presetn <= 1'b1;
		rdc("rst_mode", MODE_ADDR, 32'h0000_0000);
		rdc("rst_ctrl", CTRL_ADDR, 32'h0000_0000);
		rdc("rst_cnth", CNTH_ADDR, 32'h0000_0000);
		give_verdict;
	end
	initial
	begin
		#400_000;
		n_errors++;
		give_verdict;
	end
endmodule
`default_nettype wire
